// File: lsd_decoder.sv
`include "lsd_map.svh"

// Operation
// - First byte after frame select falls is always taken as a command.
// - Frame select rising mid-byte resets the receiver; completed bytes stay valid.
// - Command bit 6 read/write, bits 4:3 page, bits 2:0 start address.
// - Command bit 5 zero steps the pointer, one holds it; stepping after reset.
// - Bytes after a read or write command in the same frame are data for page and address; after a display code they are ignored.
// - Every read or write command latches the stepping flag; only the display codes change display enable.
// - Display enable resets off; display memory outputs are blank from the cycle after it goes off.
// - Code 0x0D with bits 6 and 4 zero turns the display on.
// - Code 0x0E with bits 6 and 4 zero turns the display off.
// - Page 01 reads return LED byte, key byte one, key byte two.
// - Key change interrupt clears once the eighth bit of each changed key byte has left.
// - Changes in the second key byte keep the interrupt until that byte is read.
// - Page 01 reads start at the given address and step at most to address 2.
// - Interrupt is active low level from a latched key change until the changed key byte is read.
// - Read bytes leave least significant bit first.
// - Every read or write command loads its start address into the pointer.
module lsd_decoder
    import lsd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        frame_select_n,
    input  wire logic        sclk,
    input  wire logic        din,
    input  wire logic        key_latch,
    input  wire logic [7:0]  key_scan0,
    input  wire logic [7:0]  key_scan1,
    output logic             dout,
    output logic             dout_oe,
    output logic             irq_n,
    output logic             display_on,
    output logic             addr_step_mode,
    output logic [55:0]      disp_mem,
    output logic [63:0]      brt_mem
);

    // ========================================================================
    // Pin synchronisation
    // ========================================================================
    logic [2:0] pins_sync;
    logic       fs_s;
    logic       sck_s;
    logic       din_s;

    // Strobe and serial clock idle high; starting the synchroniser there keeps
    // the release of reset from looking like a frame start or a clock edge.
    lsd_sync #(
        .W    (3),
        .INIT (`LSD_PIN_IDLE)
    ) u_sync (
        .clk      (clk),
        .nrst     (nrst),
        .async_in ({frame_select_n, sclk, din}),
        .sync_out (pins_sync)
    );

    assign fs_s  = pins_sync[2];
    assign sck_s = pins_sync[1];
    assign din_s = pins_sync[0];

    // ========================================================================
    // Decode helpers
    // ========================================================================
    function automatic logic [2:0] page_max(input lsd_page_t pg, input logic rd);
        case (pg)
            `LSD_PAGE_SEG: page_max = `LSD_MAX_SEG;
            `LSD_PAGE_LED: page_max = rd ? `LSD_MAX_LED_RD : `LSD_MAX_LED_WR;
            default:       page_max = `LSD_MAX_BRT;
        endcase
    endfunction

    function automatic logic [3:0] mem_idx(input lsd_page_t pg, input logic [2:0] a);
        case (pg)
            `LSD_PAGE_SEG:     mem_idx = `LSD_BASE_SEG + {1'b0, a};
            `LSD_PAGE_LED:     mem_idx = `LSD_BASE_LED + {1'b0, a};
            `LSD_PAGE_SEG_BRT: mem_idx = `LSD_BASE_SEG_BRT + {1'b0, a};
            default:           mem_idx = `LSD_BASE_LED_BRT + {1'b0, a};
        endcase
    endfunction

    // Bits 7 and 5 are don't-care in the display codes, so only bits 6 and 4 are tested for zero, beside the code in bits 3:0.
    function automatic logic is_code(input logic [7:0] b, input logic [3:0] code);
        is_code = !b[`LSD_CMD_ZERO_HI] && !b[`LSD_CMD_ZERO_LO] &&
                  (b[`LSD_CMD_CODE_HI:`LSD_CMD_CODE_LO] == code);
    endfunction

    // ========================================================================
    // State
    // ========================================================================
    lsd_state_t state_reg, state_next;
    lsd_page_t  page_reg, page_next;
    logic [2:0] ptr_reg, ptr_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] tx_reg, tx_next;
    logic       load_reg, load_next;
    logic       sck_prev_reg;
    logic       step_reg, step_next;
    logic       disp_reg, disp_next;
    logic [7:0] kbuf0_reg, kbuf0_next;
    logic [7:0] kbuf1_reg, kbuf1_next;
    logic       kchg0_reg, kchg0_next;
    logic       kchg1_reg, kchg1_next;
    logic       dout_reg, dout_next;
    logic       oe_reg, oe_next;
    logic       irq_n_reg, irq_n_next;
    logic [55:0] disp_mem_reg, disp_mem_next;
    logic [63:0] brt_mem_reg, brt_mem_next;

    logic        rise;
    logic        fall;
    logic [7:0]  byte_val;
    logic        wr_en;
    logic [3:0]  wr_idx;
    logic [7:0]  rd_data;
    logic [119:0] mem_flat;
    logic        clr0;
    logic        clr1;

    assign rise = sck_s & ~sck_prev_reg;
    assign fall = ~sck_s & sck_prev_reg;
    assign byte_val = {din_s, shift_reg[7:1]};

    lsd_mem u_mem (
        .clk      (clk),
        .nrst     (nrst),
        .wr_en    (wr_en),
        .wr_idx   (wr_idx),
        .wr_data  (byte_val),
        .rd_idx   (mem_idx(page_reg, ptr_reg)),
        .rd_data  (rd_data),
        .mem_flat (mem_flat)
    );

    // ========================================================================
    // Serial receiver and command interpreter
    // ========================================================================
    always_comb begin
        state_next = state_reg;
        page_next  = page_reg;
        ptr_next   = ptr_reg;
        cnt_next   = cnt_reg;
        shift_next = shift_reg;
        tx_next    = tx_reg;
        load_next  = 1'b0;
        step_next  = step_reg;
        disp_next  = disp_reg;
        wr_en      = 1'b0;
        wr_idx     = mem_idx(page_reg, ptr_reg);
        clr0       = 1'b0;
        clr1       = 1'b0;

        // The read byte is fetched one cycle after the pointer settles, so the
        // memory read never depends on the pointer being computed here.
        if (load_reg) begin
            if (page_reg == `LSD_PAGE_LED && ptr_reg == `LSD_ADDR_KEY0) begin
                tx_next = kbuf0_reg;
            end else if (page_reg == `LSD_PAGE_LED && ptr_reg == `LSD_ADDR_KEY1) begin
                tx_next = kbuf1_reg;
            end else begin
                tx_next = rd_data;
            end
        end

        if (fs_s) begin
            state_next = LSD_ST_CMD;
            cnt_next   = `LSD_BIT_FIRST;
        end else begin
            if (fall && state_reg == LSD_ST_RD && cnt_reg != `LSD_BIT_FIRST) begin
                tx_next = {1'b0, tx_reg[7:1]};
            end
            if (rise) begin
                shift_next = byte_val;
                cnt_next   = cnt_reg + 3'h1;
                if (cnt_reg == `LSD_BIT_LAST) begin
                    case (state_reg)
                        LSD_ST_CMD: begin
                            if (is_code(byte_val, `LSD_DISP_ON_CODE)) begin
                                disp_next  = 1'b1;
                                state_next = LSD_ST_IGN;
                            end else if (is_code(byte_val, `LSD_DISP_OFF_CODE)) begin
                                disp_next  = 1'b0;
                                state_next = LSD_ST_IGN;
                            end else begin
                                step_next = byte_val[`LSD_CMD_STEP_BIT];
                                page_next = byte_val[`LSD_CMD_PAGE_HI:`LSD_CMD_PAGE_LO];
                                ptr_next  = byte_val[`LSD_CMD_ADDR_HI:`LSD_CMD_ADDR_LO];
                                if (byte_val[`LSD_CMD_READ_BIT]) begin
                                    state_next = LSD_ST_RD;
                                    load_next  = 1'b1;
                                end else begin
                                    state_next = LSD_ST_WR;
                                end
                            end
                        end
                        LSD_ST_WR: begin
                            // Writes beyond the last address of a page are dropped.
                            wr_en = (ptr_reg <= page_max(page_reg, 1'b0));
                            if (!step_reg && ptr_reg < page_max(page_reg, 1'b0)) begin
                                ptr_next = ptr_reg + 3'h1;
                            end
                        end
                        LSD_ST_RD: begin
                            if (page_reg == `LSD_PAGE_LED) begin
                                clr0 = (ptr_reg == `LSD_ADDR_KEY0);
                                clr1 = (ptr_reg == `LSD_ADDR_KEY1);
                            end
                            if (!step_reg && ptr_reg < page_max(page_reg, 1'b1)) begin
                                ptr_next = ptr_reg + 3'h1;
                            end
                            load_next = 1'b1;
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // ========================================================================
    // Key change tracking and outputs
    // ========================================================================
    always_comb begin
        kbuf0_next = kbuf0_reg;
        kbuf1_next = kbuf1_reg;
        kchg0_next = kchg0_reg & ~clr0;
        kchg1_next = kchg1_reg & ~clr1;
        if (key_latch) begin
            kbuf0_next = key_scan0;
            kbuf1_next = key_scan1;
            // A change seen in the same cycle as a read clear is kept.
            if (key_scan0 != kbuf0_reg) begin
                kchg0_next = 1'b1;
            end
            if (key_scan1 != kbuf1_reg) begin
                kchg1_next = 1'b1;
            end
        end
        irq_n_next    = ~(kchg0_next | kchg1_next);
        dout_next     = tx_reg[0];
        oe_next       = (state_reg == LSD_ST_RD) & ~fs_s;
        disp_mem_next = disp_reg ? mem_flat[55:0] : 56'h0;
        brt_mem_next  = mem_flat[119:56];
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg    <= LSD_ST_CMD;
            page_reg     <= `LSD_PAGE_SEG;
            ptr_reg      <= 3'h0;
            cnt_reg      <= `LSD_BIT_FIRST;
            shift_reg    <= 8'h00;
            tx_reg       <= 8'h00;
            load_reg     <= 1'b0;
            sck_prev_reg <= 1'b1;
            step_reg     <= 1'b0;
            disp_reg     <= 1'b0;
            kbuf0_reg    <= 8'h00;
            kbuf1_reg    <= 8'h00;
            kchg0_reg    <= 1'b0;
            kchg1_reg    <= 1'b0;
            dout_reg     <= 1'b0;
            oe_reg       <= 1'b0;
            irq_n_reg    <= 1'b1;
            disp_mem_reg <= 56'h0;
            brt_mem_reg  <= 64'h0;
        end else begin
            state_reg    <= state_next;
            page_reg     <= page_next;
            ptr_reg      <= ptr_next;
            cnt_reg      <= cnt_next;
            shift_reg    <= shift_next;
            tx_reg       <= tx_next;
            load_reg     <= load_next;
            sck_prev_reg <= sck_s;
            step_reg     <= step_next;
            disp_reg     <= disp_next;
            kbuf0_reg    <= kbuf0_next;
            kbuf1_reg    <= kbuf1_next;
            kchg0_reg    <= kchg0_next;
            kchg1_reg    <= kchg1_next;
            dout_reg     <= dout_next;
            oe_reg       <= oe_next;
            irq_n_reg    <= irq_n_next;
            disp_mem_reg <= disp_mem_next;
            brt_mem_reg  <= brt_mem_next;
        end
    end

    assign dout           = dout_reg;
    assign dout_oe        = oe_reg;
    assign irq_n          = irq_n_reg;
    assign display_on     = disp_reg;
    assign addr_step_mode = step_reg;
    assign disp_mem       = disp_mem_reg;
    assign brt_mem        = brt_mem_reg;

endmodule // lsd_decoder

// File: lsd_map.svh
`ifndef LSD_MAP_SVH
`define LSD_MAP_SVH

// ============================================================================
// Command byte fields
// ============================================================================
`define LSD_CMD_READ_BIT     6
`define LSD_CMD_STEP_BIT     5
`define LSD_CMD_PAGE_HI      4
`define LSD_CMD_PAGE_LO      3
`define LSD_CMD_ADDR_HI      2
`define LSD_CMD_ADDR_LO      0
`define LSD_CMD_CODE_HI      3
`define LSD_CMD_CODE_LO      0
`define LSD_CMD_ZERO_HI      6
`define LSD_CMD_ZERO_LO      4
`define LSD_DISP_ON_CODE     4'hD
`define LSD_DISP_OFF_CODE    4'hE

// ============================================================================
// Memory pages
// ============================================================================
`define LSD_PAGE_SEG         2'h0
`define LSD_PAGE_LED         2'h1
`define LSD_PAGE_SEG_BRT     2'h2
`define LSD_PAGE_LED_BRT     2'h3
`define LSD_BASE_SEG         4'h0
`define LSD_BASE_LED         4'h6
`define LSD_BASE_SEG_BRT     4'h7
`define LSD_BASE_LED_BRT     4'hB
`define LSD_MAX_SEG          3'h5
`define LSD_MAX_LED_WR       3'h0
`define LSD_MAX_LED_RD       3'h2
`define LSD_MAX_BRT          3'h3
`define LSD_ADDR_KEY0        3'h1
`define LSD_ADDR_KEY1        3'h2
`define LSD_MEM_DEPTH        15
`define LSD_BRT_CFG_IDX      7
`define LSD_BRT_CFG_RESET    8'hFB
`define LSD_MEM_RESET        8'h00

// ============================================================================
// Serial framing
// ============================================================================
`define LSD_BIT_FIRST        3'h0
`define LSD_BIT_LAST         3'h7
`define LSD_PIN_IDLE         3'h6

`endif

// File: lsd_pkg.sv
package lsd_pkg;

    typedef enum logic [1:0] {
        LSD_ST_CMD = 2'b00,
        LSD_ST_WR  = 2'b01,
        LSD_ST_RD  = 2'b10,
        LSD_ST_IGN = 2'b11
    } lsd_state_t;

    typedef logic [1:0] lsd_page_t;

endpackage

// File: lsd_sync.sv
module lsd_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            stage1_reg <= INIT;
            stage2_reg <= INIT;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;

endmodule // lsd_sync

// File: lsd_mem.sv
`include "lsd_map.svh"

module lsd_mem #(
    parameter int DEPTH = `LSD_MEM_DEPTH,
    parameter int W     = 8
) (
    input  wire logic           clk,
    input  wire logic           nrst,
    input  wire logic           wr_en,
    input  wire logic [3:0]     wr_idx,
    input  wire logic [W-1:0]   wr_data,
    input  wire logic [3:0]     rd_idx,
    output logic      [W-1:0]   rd_data,
    output logic [DEPTH*W-1:0]  mem_flat
);

    logic [W-1:0] mem_reg  [DEPTH];
    logic [W-1:0] mem_next [DEPTH];

    // ========================================================================
    // Storage
    // ========================================================================
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_next[i] = mem_reg[i];
        end
        if (wr_en && (int'(wr_idx) < DEPTH)) begin
            mem_next[wr_idx] = wr_data;
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (!nrst) begin
                mem_reg[i] <= (i == `LSD_BRT_CFG_IDX) ? W'(`LSD_BRT_CFG_RESET) : W'(`LSD_MEM_RESET);
            end else begin
                mem_reg[i] <= mem_next[i];
            end
        end
    end

    assign rd_data = (int'(rd_idx) < DEPTH) ? mem_reg[rd_idx] : '0;

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_flat
            assign mem_flat[g*W +: W] = mem_reg[g];
        end
    endgenerate

endmodule // lsd_mem

// File: lsd_decoder_assertions.sv
// ======================
// Port checks of the serial command decoder
// ======================
module lsd_chk (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        frame_select_n,
    input wire logic        key_latch,
    input wire logic [7:0]  key_scan0,
    input wire logic [7:0]  key_scan1,
    input wire logic        dout_oe,
    input wire logic        irq_n,
    input wire logic        display_on,
    input wire logic        addr_step_mode,
    input wire logic [55:0] disp_mem,
    input wire logic [63:0] brt_mem
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] k0_reg;
    logic [7:0] k0_next;
    logic [7:0] k1_reg;
    logic [7:0] k1_next;

    // Shadow of the last latched key bytes, so a change can be told from a repeat.
    always_comb begin
        k0_next = key_latch ? key_scan0 : k0_reg;
        k1_next = key_latch ? key_scan1 : k1_reg;
    end
    always_ff @(posedge clk) begin
        k0_reg <= nrst ? k0_next : 8'h00;
        k1_reg <= nrst ? k1_next : 8'h00;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_reset_state; $rose(nrst) |-> !display_on && !addr_step_mode && irq_n && !dout_oe; endproperty
    a_reset_state: assert property (p_reset_state) else $error("outputs not at reset state");
    property p_blank; !display_on && !$past(display_on) |-> disp_mem == 56'h0; endproperty
    a_blank: assert property (p_blank) else $error("display memory shown while off");
    property p_oe_idle; frame_select_n [*6] |-> !dout_oe; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("dout driven outside a frame");
    property p_oe_rise; $rose(dout_oe) |-> !frame_select_n && !$past(frame_select_n, 3); endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("dout enabled without a frame");
    property p_disp_cause; $changed(display_on) |-> !$past(frame_select_n, 3); endproperty
    a_disp_cause: assert property (p_disp_cause) else $error("display flag moved outside a frame");
    property p_step_cause; $changed(addr_step_mode) |-> !$past(frame_select_n, 3); endproperty
    a_step_cause: assert property (p_step_cause) else $error("step flag moved outside a frame");
    property p_irq_set; key_latch && (key_scan0 != k0_reg || key_scan1 != k1_reg) |-> ##[1:3] !irq_n; endproperty
    a_irq_set: assert property (p_irq_set) else $error("key change did not raise interrupt");
    property p_irq_fall; $fell(irq_n) |-> $past(key_latch) || $past(key_latch, 2) || $past(key_latch, 3); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt raised without key latch");
    property p_irq_clear; $rose(irq_n) |-> !$past(frame_select_n, 2); endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("interrupt cleared outside a read");
    property p_quiet; (frame_select_n && nrst) [*8] |=> $stable(brt_mem) && $stable(disp_mem); endproperty
    a_quiet: assert property (p_quiet) else $error("memory changed between frames");
endmodule // lsd_chk

bind lsd_decoder lsd_chk lsd_chk_i (
    .clk(clk), .nrst(nrst), .frame_select_n(frame_select_n), .key_latch(key_latch),
    .key_scan0(key_scan0), .key_scan1(key_scan1), .dout_oe(dout_oe), .irq_n(irq_n),
    .display_on(display_on), .addr_step_mode(addr_step_mode), .disp_mem(disp_mem), .brt_mem(brt_mem)
);

// File: lsd_host.sv
// ======================
// Host side of the three-wire link
// ======================
module lsd_host (
    input  wire logic clk,
    input  wire logic dout,
    output logic      frame_select_n,
    output logic      sclk,
    output logic      din
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        frame_select_n = 1'b1;
        sclk           = 1'b1;
        din            = 1'b0;
    end

    task automatic open_frame();
        @(negedge clk);
        frame_select_n = 1'b0;
        repeat (4) @(negedge clk);
    endtask

    // Each phase is 4 system clocks, 400 ns a bit; dout is sampled late in the high phase.
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b0;
            din  = tx[i];
            repeat (4) @(negedge clk);
            sclk = 1'b1;
            repeat (4) @(negedge clk);
            rx[i] = dout;
        end
    endtask

    // The data line is flipped on release so a stale bit is never mistaken for data.
    task automatic close_frame();
        repeat (4) @(negedge clk);
        frame_select_n = 1'b1;
        din            = ~din;
        repeat (6) @(negedge clk);
    endtask
endmodule // lsd_host

// File: tb_top.sv
// ======================
// Self-checking bench with a reference model
// ======================
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk;
    logic        nrst;
    logic        frame_select_n;
    logic        sclk;
    logic        din;
    logic        key_latch;
    logic [7:0]  key_scan0;
    logic [7:0]  key_scan1;
    logic        dout;
    logic        dout_oe;
    logic        irq_n;
    logic        display_on;
    logic        addr_step_mode;
    logic [55:0] disp_mem;
    logic [63:0] brt_mem;
    int          mem [15];
    int          kd [2];
    bit          kf [2];
    bit          disp_on;
    bit          fixed;
    int          seed = 31807;
    int          miscompares = 0;
    int          check_count = 0;

    lsd_decoder lsd_decoder_i (
        .clk(clk), .nrst(nrst), .frame_select_n(frame_select_n), .sclk(sclk), .din(din),
        .key_latch(key_latch), .key_scan0(key_scan0), .key_scan1(key_scan1), .dout(dout),
        .dout_oe(dout_oe), .irq_n(irq_n), .display_on(display_on), .addr_step_mode(addr_step_mode),
        .disp_mem(disp_mem), .brt_mem(brt_mem)
    );
    lsd_host lsd_host_i (.clk(clk), .dout(dout), .frame_select_n(frame_select_n), .sclk(sclk), .din(din));

    function automatic logic [7:0] rnd();
        return 8'($random(seed));
    endfunction

    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check_outs();
        logic [63:0] ed;
        logic [63:0] eb;
        ed = 64'h0;
        eb = 64'h0;
        for (int i = 0; i < 8; i++) begin
            if (i < 7 && disp_on) ed[8*i +: 8] = mem[i][7:0];
            eb[8*i +: 8] = mem[7+i][7:0];
        end
        chk("display_on", 64'(display_on), 64'(disp_on));
        chk("addr_step_mode", 64'(addr_step_mode), 64'(fixed));
        chk("disp_mem", 64'(disp_mem), ed);
        chk("brt_mem", brt_mem, eb);
        chk("irq_n", 64'(irq_n), 64'(!(kf[0] || kf[1])));
        chk("dout_oe", 64'(dout_oe), 64'h0);
    endtask

    // The pointer stops at the page end, so surplus bytes land on the last address.
    task automatic run_frame(input logic [7:0] q[$], input int tail);
        logic [7:0] c;
        logic [7:0] rx;
        logic [7:0] ev;
        int         pg;
        int         ptr;
        int         mx;
        int         base;
        bit         ctl;
        c    = q[0];
        pg   = c[4:3];
        ptr  = c[2:0];
        ctl  = !c[6] && !c[4] && (c[3:0] == 4'hD || c[3:0] == 4'hE);
        base = (pg == 0) ? 0 : (pg == 1) ? 6 : (pg == 2) ? 7 : 11;
        mx   = (pg == 0) ? 5 : (pg == 1) ? (c[6] ? 2 : 0) : 3;
        if (ctl) disp_on = (c[3:0] == 4'hD);
        else fixed = c[5];
        lsd_host_i.open_frame();
        lsd_host_i.xfer(c, 8, rx);
        for (int i = 1; i < q.size(); i++) begin
            lsd_host_i.xfer(q[i], 8, rx);
            if (ctl) continue;
            if (c[6]) begin
                ev = (pg == 1 && ptr > 0) ? kd[ptr-1][7:0] : mem[base+ptr][7:0];
                chk("read byte", 64'(rx), 64'(ev));
                if (pg == 1 && ptr > 0) kf[ptr-1] = 0;
                repeat (3) @(negedge clk);
                chk("irq_n in frame", 64'(irq_n), 64'(!(kf[0] || kf[1])));
            end else if (ptr <= mx) begin
                mem[base+ptr] = q[i];
            end
            if (!fixed && ptr < mx) ptr++;
        end
        if (tail > 0) lsd_host_i.xfer(rnd(), tail, rx);
        lsd_host_i.close_frame();
        check_outs();
    endtask

    task automatic latch(input logic [7:0] a, input logic [7:0] b);
        @(negedge clk);
        key_scan0 = a;
        key_scan1 = b;
        key_latch = 1'b1;
        @(negedge clk);
        key_latch = 1'b0;
        if (a != kd[0][7:0]) kf[0] = 1;
        if (b != kd[1][7:0]) kf[1] = 1;
        kd[0] = a;
        kd[1] = b;
        repeat (4) @(negedge clk);
        chk("irq_n after latch", 64'(irq_n), 64'(!(kf[0] || kf[1])));
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        close_out();
    end

    initial begin
        logic [7:0] d [$];
        nrst      = 1'b0;
        key_latch = 1'b0;
        key_scan0 = 8'h00;
        key_scan1 = 8'h00;
        mem       = '{default: 0};
        mem[7]    = 8'hFB;
        kd        = '{0, 0};
        kf        = '{0, 0};
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        check_outs();
        d = {8'h00, rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
        run_frame(d, 0);
        d = {(rnd() & 8'hA0) | 8'h0D};
        run_frame(d, 0);
        d = {8'h31, rnd(), rnd()};
        run_frame(d, 0);
        d = {8'h1A, rnd(), rnd(), rnd()};
        run_frame(d, 0);
        d = {8'h50, rnd(), rnd()};
        run_frame(d, 0);
        d = {8'h5A, rnd(), rnd(), rnd()};
        run_frame(d, 0);
        d = {8'h63, rnd(), rnd()};
        run_frame(d, 0);
        d = {8'h08, rnd()};
        run_frame(d, 5);
        d = {(rnd() & 8'hA0) | 8'h0E};
        run_frame(d, 0);
        latch(rnd() | 8'h01, 8'h00);
        d = {8'h49, rnd()};
        run_frame(d, 0);
        d = {8'h0D};
        run_frame(d, 0);
        latch(kd[0][7:0], rnd() | 8'h01);
        d = {8'h48, rnd(), rnd(), rnd(), rnd()};
        run_frame(d, 0);
        close_out();
    end
endmodule // tb_top
